/* File: design/dcp_pkg.sv */
// Package with the constants and types of the DSP and sample clock PLL block.
package dcp_pkg;

    // Register byte addresses.
    localparam logic [7:0] ADDR_CORE_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_CORE_IN    = 8'h04;
    localparam logic [7:0] ADDR_CORE_STAT  = 8'h08;
    localparam logic [7:0] ADDR_FRAME_CTRL = 8'h0c;
    localparam logic [7:0] ADDR_FRAME_STAT = 8'h10;
    localparam logic [7:0] ADDR_FLAGS      = 8'h14;

    // Field positions.
    localparam int CORE_TURBO_BIT   = 5;
    localparam int STAT_OVER_BIT    = 20;
    localparam int STAT_VALID_BIT   = 21;
    localparam int STAT_HALVE_BIT   = 22;
    localparam int STAT_LOCK_BIT    = 23;
    localparam int FRAME_MULT_LSB   = 2;
    localparam int FRAME_LOCK_BIT   = 16;
    localparam int FLAG_DRV_LSB     = 3;
    localparam int FLAG_PIN_LSB     = 8;

    // Values after reset.
    localparam logic [4:0]  RST_DIV_CODE = 5'h00;
    localparam logic        RST_TURBO    = 1'b1;
    localparam logic [15:0] RST_IN_KHZ   = 16'h3000;
    localparam logic [1:0]  RST_RANGE    = 2'h1;
    localparam logic [2:0]  RST_MULT_SEL = 3'h2;

    // Divider codes and their multiplication factors.
    localparam logic [4:0] CODE_10H = 5'h10;
    localparam logic [4:0] CODE_09H = 5'h09;
    localparam logic [4:0] CODE_03H = 5'h03;
    localparam logic [4:0] CODE_00H = 5'h00;
    localparam logic [4:0] CODE_0BH = 5'h0b;
    localparam logic [8:0] FACT_10H = 9'd272;
    localparam logic [8:0] FACT_09H = 9'd227;
    localparam logic [8:0] FACT_03H = 9'd198;
    localparam logic [8:0] FACT_00H = 9'd181;
    localparam logic [8:0] FACT_0BH = 9'd244;
    localparam int         FACT_SHIFT = 5;
    localparam logic [19:0] CORE_MAX_KHZ = 20'd70000;

    // Frame PLL settings.
    localparam logic [1:0] RANGE_LOW  = 2'h1;
    localparam logic [1:0] RANGE_HIGH = 2'h0;
    localparam logic [2:0] MSEL_512 = 3'h4;
    localparam logic [2:0] MSEL_384 = 3'h3;
    localparam logic [2:0] MSEL_256 = 3'h2;
    localparam logic [2:0] MSEL_192 = 3'h1;
    localparam logic [2:0] MSEL_128 = 3'h0;
    localparam logic [15:0] FRAME_TOL = 16'h0002;

    // Timing.
    localparam int CLK_KHZ        = 10000;
    localparam int CORE_SETTLE_NS = 50000;
    localparam int CORE_SETTLE_CYC = (CORE_SETTLE_NS * (CLK_KHZ / 1000) + 999) / 1000;

    typedef struct packed {
        logic [2:0] value;
        logic [2:0] oe_n;
    } dcp_flag_drive_type;

endpackage

/* File: design/dcp_clock_ctrl.sv */
// Clock control for the DSP core PLL and the frame-locked sample clock PLL.
`timescale 1ns/1ns
`default_nettype none
module dcp_clock_ctrl
(
    // Clock and reset.
    input  wire logic        CLK_SYS,
    input  wire logic        SRST,
    // Wishbone slave.
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output var  logic        WB_ACK_O,
    output var  logic [31:0] WB_DAT_O,
    // Core PLL.
    input  wire logic        HALVE_CLK_IN,
    output var  logic        CORE_REF_HALF,
    output var  logic [19:0] CORE_FREQ_KHZ,
    output var  logic        CORE_PLL_LOCKED,
    // Frame PLL.
    input  wire logic        FRAME_SYNC_INPUT,
    output var  logic        SAMPLE_MULTIPLE_CLOCK_OUT,
    output var  logic        FRAME_LOCKED_PLL,
    // Flag pins.
    input  wire logic        CORE_FLAG_PIN_A_I,
    input  wire logic        CORE_FLAG_PIN_B_I,
    input  wire logic        CORE_FLAG_PIN_C_I,
    output var  logic        CORE_FLAG_PIN_A_O,
    output var  logic        CORE_FLAG_PIN_B_O,
    output var  logic        CORE_FLAG_PIN_C_O,
    output var  logic        CORE_FLAG_PIN_A_OE_N,
    output var  logic        CORE_FLAG_PIN_B_OE_N,
    output var  logic        CORE_FLAG_PIN_C_OE_N
);

    typedef struct packed {
        logic                    ack;
        logic [31:0]             rdata;
        logic [4:0]              div_code;
        logic                    turbo;
        logic [15:0]             in_khz;
        logic [1:0]              range;
        logic [2:0]              mult_sel;
        logic [2:0]              flag_val;
        logic [2:0]              flag_drv;
        dcp_pkg::dcp_flag_drive_type pins;
        logic                    halve;
        logic                    ref_half;
        logic [19:0]             core_khz;
        logic [15:0]             settle;
        logic                    core_lock;
        logic                    fs_q;
        logic [15:0]             fs_cnt;
        logic [15:0]             period;
        logic                    fs_lock;
        logic [19:0]             acc;
        logic [1:0]              phase;
        logic                    smp_clk;
    } dcp_state_type;

    dcp_state_type st;
    dcp_state_type next_st;

    logic [8:0]  factor;
    logic        code_valid;
    logic [15:0] eff_khz;
    logic [24:0] product;
    logic [19:0] raw_khz;
    logic [9:0]  multiple;
    logic        duty_third;
    logic [19:0] step;
    logic [19:0] acc_sum;
    logic [15:0] diff;
    logic        fs_rise;
    logic        req;
    logic [2:0]  pin_level;
    logic        core_steady;
    logic        core_in_range;

    // Factor for each known divider code; other codes leave the core PLL unlocked.
    always_comb
    begin
        factor = 9'h000;
        code_valid = 1'b1;
        case (st.div_code)
            dcp_pkg::CODE_10H: factor = dcp_pkg::FACT_10H;
            dcp_pkg::CODE_09H: factor = dcp_pkg::FACT_09H;
            dcp_pkg::CODE_03H: factor = dcp_pkg::FACT_03H;
            dcp_pkg::CODE_00H: factor = dcp_pkg::FACT_00H;
            dcp_pkg::CODE_0BH: factor = dcp_pkg::FACT_0BH;
            default:           code_valid = 1'b0;
        endcase
    end

    // Output multiple and duty selection.
    always_comb
    begin
        duty_third = 1'b0;
        case (st.mult_sel)
            dcp_pkg::MSEL_512:
            begin
                multiple = 10'd512;
                duty_third = (st.range == dcp_pkg::RANGE_HIGH);
            end
            dcp_pkg::MSEL_384: multiple = 10'd384;
            dcp_pkg::MSEL_256: multiple = 10'd256;
            dcp_pkg::MSEL_192: multiple = 10'd192;
            default:           multiple = 10'd128;
        endcase
    end

    assign pin_level = {CORE_FLAG_PIN_C_I, CORE_FLAG_PIN_B_I, CORE_FLAG_PIN_A_I};
    assign req       = WB_CYC_I && WB_STB_I && !st.ack;

    always_comb
    begin
        next_st = st;
        // Halved input is what the core PLL sees when the pin is high.
        eff_khz = st.halve ? {1'b0, st.in_khz[15:1]} : st.in_khz;
        product = eff_khz * factor;
        raw_khz = product[24:dcp_pkg::FACT_SHIFT];
        if (!st.turbo)
        begin
            raw_khz = {1'b0, raw_khz[19:1]};
        end
        if (duty_third)
        begin
            step = 20'(multiple * 3);
        end
        else
        begin
            step = 20'(multiple * 2);
        end
        acc_sum = st.acc + step;
        fs_rise = FRAME_SYNC_INPUT && !st.fs_q;
        if (st.fs_cnt > st.period)
        begin
            diff = st.fs_cnt - st.period;
        end
        else
        begin
            diff = st.period - st.fs_cnt;
        end
        // Lock is judged on the value being registered, so it never stands beside an out-of-range frequency.
        core_steady   = (raw_khz == st.core_khz) && (st.halve == HALVE_CLK_IN);
        core_in_range = (raw_khz != 20'h00000) && (raw_khz <= dcp_pkg::CORE_MAX_KHZ);

        // Bus slave: one wait state, ack drops in the cycle after it was given.
        next_st.ack = req;
        next_st.rdata = 32'h0000_0000;
        if (req && WB_WE_I)
        begin
            if (WB_ADR_I == dcp_pkg::ADDR_CORE_CTRL)
            begin
                if (WB_SEL_I[0])
                begin
                    next_st.div_code = WB_DAT_I[4:0];
                    next_st.turbo = WB_DAT_I[dcp_pkg::CORE_TURBO_BIT];
                end
            end
            else if (WB_ADR_I == dcp_pkg::ADDR_CORE_IN)
            begin
                if (WB_SEL_I[0])
                begin
                    next_st.in_khz[7:0] = WB_DAT_I[7:0];
                end
                if (WB_SEL_I[1])
                begin
                    next_st.in_khz[15:8] = WB_DAT_I[15:8];
                end
            end
            else if (WB_ADR_I == dcp_pkg::ADDR_FRAME_CTRL)
            begin
                if (WB_SEL_I[0])
                begin
                    next_st.range = WB_DAT_I[1:0];
                    next_st.mult_sel = WB_DAT_I[dcp_pkg::FRAME_MULT_LSB +: 3];
                end
            end
            else if (WB_ADR_I == dcp_pkg::ADDR_FLAGS)
            begin
                if (WB_SEL_I[0])
                begin
                    next_st.flag_val = WB_DAT_I[2:0];
                    next_st.flag_drv = WB_DAT_I[dcp_pkg::FLAG_DRV_LSB +: 3];
                end
            end
        end
        else if (req)
        begin
            if (WB_ADR_I == dcp_pkg::ADDR_CORE_CTRL)
            begin
                next_st.rdata = {26'h0, st.turbo, st.div_code};
            end
            else if (WB_ADR_I == dcp_pkg::ADDR_CORE_IN)
            begin
                next_st.rdata = {16'h0, st.in_khz};
            end
            else if (WB_ADR_I == dcp_pkg::ADDR_CORE_STAT)
            begin
                next_st.rdata = {8'h0, st.core_lock, st.halve, code_valid,
                                 (st.core_khz > dcp_pkg::CORE_MAX_KHZ), st.core_khz};
            end
            else if (WB_ADR_I == dcp_pkg::ADDR_FRAME_CTRL)
            begin
                next_st.rdata = {27'h0, st.mult_sel, st.range};
            end
            else if (WB_ADR_I == dcp_pkg::ADDR_FRAME_STAT)
            begin
                next_st.rdata = {15'h0, st.fs_lock, st.period};
            end
            else if (WB_ADR_I == dcp_pkg::ADDR_FLAGS)
            begin
                next_st.rdata = {21'h0, pin_level, 2'h0, st.flag_drv, st.flag_val};
            end
        end

        // Flag pins: enable is low while the pin is driven.
        next_st.pins.value = st.flag_val;
        next_st.pins.oe_n  = ~st.flag_drv;

        // Core PLL: halved reference and settling after any change.
        next_st.halve = HALVE_CLK_IN;
        next_st.ref_half = st.halve ? !st.ref_half : 1'b0;
        next_st.core_khz = raw_khz;
        if (!core_steady)
        begin
            next_st.settle = 16'(dcp_pkg::CORE_SETTLE_CYC);
        end
        else if (st.settle != 16'h0000)
        begin
            next_st.settle = st.settle - 16'h0001;
        end
        // Lock is held low while the core clock is zero or above its limit; the frequency itself is not clamped.
        next_st.core_lock = (st.settle == 16'h0000) && code_valid && core_steady && core_in_range;

        // Frame PLL: measure the frame period and lock on two matching periods.
        next_st.fs_q = FRAME_SYNC_INPUT;
        if (fs_rise)
        begin
            next_st.fs_cnt = 16'h0001;
            next_st.period = st.fs_cnt;
            next_st.fs_lock = (diff <= dcp_pkg::FRAME_TOL) && (st.fs_cnt != 16'h0000);
        end
        else if (st.fs_cnt != 16'hffff)
        begin
            next_st.fs_cnt = st.fs_cnt + 16'h0001;
        end
        else
        begin
            next_st.fs_lock = 1'b0;
        end

        // Phase accumulator: 2 or 3 steps per output period, restarting at each frame sync rise.
        if (!st.fs_lock || st.period == 16'h0000)
        begin
            next_st.acc = 20'h00000;
            next_st.phase = 2'h0;
            next_st.smp_clk = 1'b0;
        end
        else
        begin
            if (fs_rise)
            begin
                next_st.acc = 20'h00000;
                next_st.phase = 2'h0;
            end
            else if (acc_sum >= {4'h0, st.period})
            begin
                next_st.acc = acc_sum - {4'h0, st.period};
                if (next_st.acc >= {4'h0, st.period})
                begin
                    next_st.acc = 20'h00000;
                end
                if (duty_third)
                begin
                    next_st.phase = (st.phase == 2'h2) ? 2'h0 : st.phase + 2'h1;
                end
                else
                begin
                    next_st.phase = {1'b0, !st.phase[0]};
                end
            end
            else
            begin
                next_st.acc = acc_sum;
            end
            next_st.smp_clk = duty_third ? (next_st.phase != 2'h2) : !next_st.phase[0];
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            st.ack       <= 1'b0;
            st.rdata     <= 32'h0000_0000;
            st.div_code  <= dcp_pkg::RST_DIV_CODE;
            st.turbo     <= dcp_pkg::RST_TURBO;
            st.in_khz    <= dcp_pkg::RST_IN_KHZ;
            st.range     <= dcp_pkg::RST_RANGE;
            st.mult_sel  <= dcp_pkg::RST_MULT_SEL;
            st.flag_val  <= 3'h0;
            st.flag_drv  <= 3'h0;
            st.pins      <= '{value: 3'h0, oe_n: 3'h7};
            st.halve     <= 1'b0;
            st.ref_half  <= 1'b0;
            st.core_khz  <= 20'h00000;
            st.settle    <= 16'(dcp_pkg::CORE_SETTLE_CYC);
            st.core_lock <= 1'b0;
            st.fs_q      <= 1'b0;
            st.fs_cnt    <= 16'h0000;
            st.period    <= 16'h0000;
            st.fs_lock   <= 1'b0;
            st.acc       <= 20'h00000;
            st.phase     <= 2'h0;
            st.smp_clk   <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign WB_ACK_O                  = st.ack;
    assign WB_DAT_O                  = st.rdata;
    assign CORE_REF_HALF             = st.ref_half;
    assign CORE_FREQ_KHZ             = st.core_khz;
    assign CORE_PLL_LOCKED           = st.core_lock;
    assign SAMPLE_MULTIPLE_CLOCK_OUT = st.smp_clk;
    assign FRAME_LOCKED_PLL          = st.fs_lock;
    assign CORE_FLAG_PIN_A_O         = st.pins.value[0];
    assign CORE_FLAG_PIN_B_O         = st.pins.value[1];
    assign CORE_FLAG_PIN_C_O         = st.pins.value[2];
    assign CORE_FLAG_PIN_A_OE_N      = st.pins.oe_n[0];
    assign CORE_FLAG_PIN_B_OE_N      = st.pins.oe_n[1];
    assign CORE_FLAG_PIN_C_OE_N      = st.pins.oe_n[2];

endmodule
`default_nettype wire

/* File: bench/dcp_audio_source.sv */
// Model of the audio source frame sync and of the board wiring of the flag pins.
`timescale 1ns/1ns
`default_nettype none
module dcp_audio_source
(
    // Clock and control.
    input  wire logic                        clk,
    input  wire logic                        run,
    input  wire logic [15:0]                 period,
    // Frame sync.
    output var  logic                        frame_sync,
    // Flag pins.
    input  wire dcp_pkg::dcp_flag_drive_type dev,
    input  wire logic [2:0]                  ext_en,
    input  wire logic [2:0]                  ext_val,
    output var  logic [2:0]                  pins
);
    logic [15:0] cnt = 16'h0;
    // The line rests low between runs because run gates it.
    always @(posedge clk)
    begin
        cnt <= (!run || cnt >= period - 16'h1) ? 16'h0 : cnt + 16'h1;
        frame_sync <= run && cnt < (period >> 1);
    end
    // A pin nobody drives is pulled down.
    always_comb
        for (int i = 0; i < 3; i++)
            pins[i] = !dev.oe_n[i] ? dev.value[i] : (ext_en[i] ? ext_val[i] : 1'b0);
endmodule
`default_nettype wire

/* File: bench/dcp_clock_ctrl_monitor.sv */
// Checker of bus, core PLL, frame PLL and flag pin timing.
`timescale 1ns/1ns
`default_nettype none
module dcp_clock_ctrl_monitor
(
    // Clock and reset.
    input wire logic        CLK_SYS,
    input wire logic        SRST,
    // Bus.
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [7:0]  WB_ADR_I,
    input wire logic        WB_ACK_O,
    input wire logic [31:0] WB_DAT_O,
    // Clocks.
    input wire logic        HALVE_CLK_IN,
    input wire logic        CORE_REF_HALF,
    input wire logic [19:0] CORE_FREQ_KHZ,
    input wire logic        CORE_PLL_LOCKED,
    input wire logic        FRAME_SYNC_INPUT,
    input wire logic        SAMPLE_MULTIPLE_CLOCK_OUT,
    input wire logic        FRAME_LOCKED_PLL,
    // Flag pins.
    input wire logic        CORE_FLAG_PIN_A_I,
    input wire logic        CORE_FLAG_PIN_B_I,
    input wire logic        CORE_FLAG_PIN_C_I
);
    int unsigned low_cnt;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);
    // Counts the cycles for which the core PLL has been out of lock.
    always_ff @(posedge CLK_SYS)
        low_cnt <= (SRST || CORE_PLL_LOCKED) ? 0 : low_cnt + 1;
    sequence taken_s;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence flag_read_s;
        taken_s ##0 (!WB_WE_I && WB_ADR_I == dcp_pkg::ADDR_FLAGS) ##1 WB_ACK_O;
    endsequence
    bus_answer_a: assert property (taken_s |=> WB_ACK_O) else $error("ack missing");
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
    data_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("data without ack");
    flag_read_a: assert property
        (flag_read_s |-> WB_DAT_O[10:8] == $past({CORE_FLAG_PIN_C_I, CORE_FLAG_PIN_B_I, CORE_FLAG_PIN_A_I}))
        else $error("flag levels wrong");
    halve_toggle_a: assert property
        (!$past(SRST) && !$past(SRST, 2) && $past(HALVE_CLK_IN) && $past(HALVE_CLK_IN, 2)
        |-> CORE_REF_HALF != $past(CORE_REF_HALF)) else $error("reference not halved");
    core_max_a: assert property
        (CORE_PLL_LOCKED |-> CORE_FREQ_KHZ != 20'h0 && CORE_FREQ_KHZ <= dcp_pkg::CORE_MAX_KHZ)
        else $error("locked out of range");
    lock_drop_a: assert property
        ($changed(CORE_FREQ_KHZ) |-> ##[0:1] !CORE_PLL_LOCKED) else $error("lock kept");
    settle_time_a: assert property
        ($rose(CORE_PLL_LOCKED) |-> low_cnt >= dcp_pkg::CORE_SETTLE_CYC - 1) else $error("lock early");
    sample_idle_a: assert property
        (!FRAME_LOCKED_PLL && !$past(FRAME_LOCKED_PLL) |-> !SAMPLE_MULTIPLE_CLOCK_OUT)
        else $error("clock while unlocked");
    frame_lock_a: assert property
        ($rose(FRAME_LOCKED_PLL) |-> $past(FRAME_SYNC_INPUT) || $past(FRAME_SYNC_INPUT, 2))
        else $error("lock off frame edge");
endmodule
bind dcp_clock_ctrl dcp_clock_ctrl_monitor mon_u
(
    .CLK_SYS(CLK_SYS), .SRST(SRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O), .HALVE_CLK_IN(HALVE_CLK_IN),
    .CORE_REF_HALF(CORE_REF_HALF), .CORE_FREQ_KHZ(CORE_FREQ_KHZ), .CORE_PLL_LOCKED(CORE_PLL_LOCKED),
    .FRAME_SYNC_INPUT(FRAME_SYNC_INPUT), .SAMPLE_MULTIPLE_CLOCK_OUT(SAMPLE_MULTIPLE_CLOCK_OUT),
    .FRAME_LOCKED_PLL(FRAME_LOCKED_PLL), .CORE_FLAG_PIN_A_I(CORE_FLAG_PIN_A_I),
    .CORE_FLAG_PIN_B_I(CORE_FLAG_PIN_B_I), .CORE_FLAG_PIN_C_I(CORE_FLAG_PIN_C_I)
);
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the clock control block.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    // Row: halve, turbo, code[4:0], factor[8:0], input kHz[15:0].
    localparam logic [31:0] core_tab [10] = '{32'h61102000, 32'h52e32600, 32'h46c62c1a, 32'h40b53000,
        32'he1104000, 32'hd2e34c00, 32'hc0b56000, 32'hd6f44800, 32'h00b53000, 32'h7e003000};
    localparam logic [39:0] rst_tab [5] = '{40'h0000000020, 40'h0400003000, 40'h0c00000009,
        40'h1400000000, 40'h4000000000};
    // Row: frame control byte, expected multiple.
    localparam logic [19:0] frm_tab [8] = '{20'h01080, 20'h050c0, 20'h09100, 20'h0d180, 20'h11200,
        20'h10200, 20'h00080, 20'h15080};
    logic        clk_sys = 1'b0;
    logic        srst = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, halve = 1'b0, run = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, rd, e, p;
    logic [2:0]  ext_en = 3'h0, ext_val = 3'h0, pins;
    logic [19:0] freq, f;
    logic        ack, locked, fsync, sclk, flocked, ok, refh, refh0;
    wire dcp_pkg::dcp_flag_drive_type dev;
    int          n_mismatch = 0;
    int          checked = 0;
    dcp_clock_ctrl dut_u
    (
        .CLK_SYS(clk_sys), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_ACK_O(ack), .WB_DAT_O(rdat),
        .HALVE_CLK_IN(halve), .CORE_REF_HALF(refh), .CORE_FREQ_KHZ(freq), .CORE_PLL_LOCKED(locked),
        .FRAME_SYNC_INPUT(fsync), .SAMPLE_MULTIPLE_CLOCK_OUT(sclk), .FRAME_LOCKED_PLL(flocked),
        .CORE_FLAG_PIN_A_I(pins[0]), .CORE_FLAG_PIN_B_I(pins[1]), .CORE_FLAG_PIN_C_I(pins[2]),
        .CORE_FLAG_PIN_A_O(dev.value[0]), .CORE_FLAG_PIN_B_O(dev.value[1]),
        .CORE_FLAG_PIN_C_O(dev.value[2]), .CORE_FLAG_PIN_A_OE_N(dev.oe_n[0]),
        .CORE_FLAG_PIN_B_OE_N(dev.oe_n[1]), .CORE_FLAG_PIN_C_OE_N(dev.oe_n[2])
    );
    dcp_audio_source src_u
    (
        .clk(clk_sys), .run(run), .period(16'h07d0), .frame_sync(fsync),
        .dev(dev), .ext_en(ext_en), .ext_val(ext_val), .pins(pins)
    );
    always #50 clk_sys = ~clk_sys;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        rd = rdat;
        if (n >= 20)
            n_mismatch++;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic frame_run(input logic [19:0] r);
        int rises, high, exp_h;
        logic prev;
        rises = 0;
        high = 0;
        prev = 1'b0;
        exp_h = (r[19:12] == 8'h10) ? 1333 : 1000;
        wb(1'b1, 8'h0c, {24'h0, r[19:12]}, 4'h1);
        for (int i = 0; i < 6000 && flocked !== 1'b1; i++)
            @(posedge clk_sys);
        @(posedge fsync);
        @(posedge clk_sys);
        repeat (2000)
        begin
            @(posedge clk_sys);
            rises += (sclk === 1'b1 && prev === 1'b0);
            high += (sclk === 1'b1);
            prev = sclk;
        end
        chk(32'(rises >= r[11:0] - 1 && rises <= r[11:0] + 1), 32'h1);
        chk(32'(high > exp_h - 60 && high < exp_h + 60), 32'h1);
    endtask
    task automatic wrap_up;
        if (n_mismatch == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        #5000000;
        n_mismatch++;
        wrap_up();
    end
    initial
    begin
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
        run <= 1'b1;
        wb(1'b1, 8'h40, 32'hffffffff, 4'hf);
        for (int i = 0; i < 5; i++)
        begin
            wb(1'b0, rst_tab[i][39:32], 32'h0, 4'h0);
            chk(rd, rst_tab[i][31:0]);
        end
        for (int i = 0; i < 10; i++)
        begin
            e = core_tab[i];
            halve <= e[31];
            wb(1'b1, 8'h04, {16'h0, e[15:0]}, 4'h3);
            wb(1'b1, 8'h00, {26'h0, e[30:25]}, 4'h1);
            p = ({16'h0, e[15:0]} >> e[31]) * {23'h0, e[24:16]};
            f = 20'(p >> (e[30] ? 5 : 6));
            ok = e[24:16] != 9'h0 && f != 20'h0 && f <= 20'h11170;
            repeat (3) @(posedge clk_sys);
            for (int j = 0; j < 700 && locked !== 1'b1; j++)
                @(posedge clk_sys);
            refh0 = refh;
            @(posedge clk_sys);
            chk({31'h0, refh ^ refh0}, {31'h0, e[31]});
            chk({12'h0, freq}, {12'h0, f});
            wb(1'b0, 8'h08, 32'h0, 4'h0);
            chk(rd, {8'h0, ok, e[31], e[24:16] != 9'h0, f > 20'h11170, f});
        end
        wb(1'b1, 8'h00, 32'h0, 4'he);
        wb(1'b0, 8'h00, 32'h0, 4'h0);
        chk(rd, 32'h0000003f);
        ext_en <= 3'h2;
        ext_val <= 3'h2;
        wb(1'b1, 8'h14, 32'h0000002d, 4'h1);
        repeat (4) @(posedge clk_sys);
        chk({26'h0, dev}, 32'h0000002a);
        wb(1'b0, 8'h14, 32'h0, 4'h0);
        chk(rd, 32'h0000072d);
        ext_en <= 3'h5;
        ext_val <= 3'h1;
        wb(1'b1, 8'h14, 32'h00000007, 4'h1);
        repeat (4) @(posedge clk_sys);
        wb(1'b0, 8'h14, 32'h0, 4'h0);
        chk(rd, 32'h00000107);
        for (int i = 0; i < 8; i++)
            frame_run(frm_tab[i]);
        wb(1'b0, 8'h10, 32'h0, 4'h0);
        chk(rd, 32'h000107d0);
        wrap_up();
    end
endmodule
`default_nettype wire
